// >>> logic/aspc_pkg.sv
// Purpose: Shared constants and types for the converter serial port pin control.
// Assumes: System clock of 10 MHz, period 100 ns.
// Notes: Times are kept in their printed units and converted to cycles here.
package aspc_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int START_LOW_MODE0_NS = 40;
   localparam int START_LOW_MODE1_NS = 1400;
   localparam int CONV_MAX_NS = 7000;
   localparam int REF_WAKE_MAX_NS = 65000;
   localparam int START_LOW_MODE1_CYC = (START_LOW_MODE1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
   localparam int REF_WAKE_MAX_CYC = REF_WAKE_MAX_NS / CLK_PERIOD_NS;
   localparam int CONV_CLOCKS = 16;
   localparam int CONV_CLK_DIV = 4;
   localparam int MODE_LSB_POS = 4;
   localparam int MODE_MSB_POS = 5;
   localparam int START_PIN_POS = 2;
   localparam logic [7:0] SETUP_MARK = 8'h40;
   localparam logic [7:0] SETUP_MARK_MASK = 8'hc0;
   localparam logic [7:0] SETUP_RESET = 8'h60;
   localparam logic [7:0] CONVERT_MARK = 8'h80;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   typedef enum logic [1:0] {
      ASPC_MODE_PIN_INT = 2'b00,
      ASPC_MODE_PIN_EXT = 2'b01,
      ASPC_MODE_SERIAL = 2'b10,
      ASPC_MODE_SCLK = 2'b11
   } aspc_mode_type;

   typedef enum logic [1:0] {
      ASPC_IDLE = 2'b00,
      ASPC_WAKE = 2'b01,
      ASPC_CONV = 2'b10
   } aspc_state_type;

   typedef struct packed {
      logic select_n;
      logic sclk;
      logic din;
      logic start_or_analog_input_15;
   } aspc_pins_type;
endpackage : aspc_pkg

// >>> logic/aspc_port.sv
// Purpose: Serial port pin control and conversion handshake of a multichannel converter.
// Assumes: All pins are asynchronous to clk and are synchronised; serial clock well below clk/4.
// Notes: The converter core is modelled as a timed result source.
// Functional notes
// - Serial traffic is taken only while select is low; clock and data are ignored while it is high.
// - The data output is released whenever select is high and driven only while select is low.
// - The data input is sampled on each rising serial clock edge, and the master keeps it stable there.
// - The data output bit changes only on falling serial clock edges and when select falls.
// - End of conversion goes low once results are ready, except in mode 11 where it stays high, and results are not valid before that.
// - The highest analog input doubles as the conversion start input, its role chosen by setup.
// - End of conversion follows select or start rising within 7 us, plus up to 65 us of reference wake.
// - Conversion latency is the conversion clock count times the conversion clock period.
// - The clock mode comes from bits 5 and 4 of the setup byte.
// - In modes 00 and 10 end of conversion goes low when done and high when select falls, or in mode 00 when start falls.
`timescale 1ns/100ps
module aspc_port
   import aspc_pkg::*;
#(
   parameter int REF_WAKE_CYC = REF_WAKE_MAX_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire aspc_pins_type pins,
   input wire logic ref_needs_wake,
   input wire logic [11:0] sample_value,
   output logic dout,
   output logic dout_oe,
   output logic eoc_n,
   output logic [7:0] setup,
   output logic [15:0] result
);
   aspc_pins_type sync1;
   aspc_pins_type sync2;
   aspc_pins_type prev;
   aspc_state_type state;
   logic [7:0] shift_in;
   logic [2:0] bit_count;
   logic [15:0] shift_out;
   logic [16:0] timer;
   logic [15:0] low_count;
   logic selected;
   logic sclk_rise;
   logic sclk_fall;
   logic byte_done;
   logic pin_is_start;
   logic start_fall;
   logic start_rise;
   logic sel_fall;
   logic sel_rise;
   logic start_ok;
   logic [16:0] next_timer;
   aspc_mode_type mode;

   always_ff @(posedge clk) begin
      if (reset) begin
         sync1 <= '1;
         sync2 <= '1;
         prev <= '1;
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
         prev <= sync2;
      end
   end

   assign mode = aspc_mode_type'(setup[MODE_MSB_POS:MODE_LSB_POS]);
   assign pin_is_start = (mode == ASPC_MODE_PIN_INT) || (mode == ASPC_MODE_PIN_EXT);
   assign selected = !sync2.select_n;
   assign sclk_rise = selected && sync2.sclk && !prev.sclk;
   assign sclk_fall = selected && !sync2.sclk && prev.sclk;
   assign sel_fall = !sync2.select_n && prev.select_n;
   assign sel_rise = sync2.select_n && !prev.select_n;
   assign start_fall = pin_is_start && !sync2.start_or_analog_input_15 && prev.start_or_analog_input_15;
   assign start_rise = pin_is_start && sync2.start_or_analog_input_15 && !prev.start_or_analog_input_15;
   assign start_ok = (mode == ASPC_MODE_PIN_INT) || (low_count >= 16'(START_LOW_MODE1_CYC));
   assign byte_done = sclk_rise && (bit_count == 3'h7);

   always_ff @(posedge clk) begin
      if (reset || sel_fall) begin
         bit_count <= 3'h0;
         shift_in <= 8'h00;
      end else if (sclk_rise) begin
         bit_count <= bit_count + 3'h1;
         shift_in <= {shift_in[6:0], sync2.din};
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         setup <= SETUP_RESET;
      end else if (byte_done && (({shift_in[6:0], sync2.din} & SETUP_MARK_MASK) == SETUP_MARK)) begin
         setup <= {shift_in[6:0], sync2.din};
      end
   end

   // Counts the low cycles of the start pin and keeps the count past its rise, saturating at the top.
   always_ff @(posedge clk) begin
      if (reset) begin
         low_count <= 16'h0000;
      end else if (!sync2.start_or_analog_input_15 && prev.start_or_analog_input_15) begin
         low_count <= 16'h0001;
      end else if (!sync2.start_or_analog_input_15 && low_count != 16'hffff) begin
         low_count <= low_count + 16'h0001;
      end
   end

   always_comb begin
      next_timer = timer - 17'h00001;
      if (timer == 17'h00000) begin
         next_timer = 17'h00000;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= ASPC_IDLE;
         timer <= 17'h00000;
      end else begin
         case (state)
            ASPC_IDLE: begin
               if ((sel_rise && mode == ASPC_MODE_SERIAL) || (start_rise && start_ok)) begin
                  state <= ref_needs_wake ? ASPC_WAKE : ASPC_CONV;
                  timer <= ref_needs_wake ? 17'(REF_WAKE_CYC - 1) : 17'(CONV_CLOCKS * CONV_CLK_DIV - 1);
               end
            end
            ASPC_WAKE: begin
               timer <= next_timer;
               if (timer == 17'h00000) begin
                  state <= ASPC_CONV;
                  timer <= 17'(CONV_CLOCKS * CONV_CLK_DIV - 1);
               end
            end
            default: begin
               timer <= next_timer;
               if (timer == 17'h00000) begin
                  state <= ASPC_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         result <= RESULT_RESET;
         eoc_n <= 1'b1;
      end else if (state == ASPC_CONV && timer == 17'h00000) begin
         result <= {4'h0, sample_value};
         eoc_n <= (mode == ASPC_MODE_SCLK);
      end else if (sel_fall || start_fall) begin
         eoc_n <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         shift_out <= 16'h0000;
         dout <= 1'b0;
      end else if (sel_fall) begin
         shift_out <= {result[14:0], 1'b0};
         dout <= result[15];
      end else if (sclk_fall) begin
         dout <= shift_out[15];
         shift_out <= {shift_out[14:0], 1'b0};
      end
   end

   assign dout_oe = selected;

   a_oe_follows_select: assert property (@(posedge clk) disable iff (reset) dout_oe == !$past(sync1.select_n))
      else $error("Data output enable does not follow select.");
   a_dout_falling_only: assert property (@(posedge clk) disable iff (reset)
      $changed(dout) |-> $past(sclk_fall) || $past(sel_fall))
      else $error("Data output changed away from a falling edge.");
   a_idle_no_shift: assert property (@(posedge clk) disable iff (reset)
      sync2.select_n && !sel_rise |=> $stable(bit_count))
      else $error("Input bits counted while deselected.");
   a_eoc_done_low: assert property (@(posedge clk) disable iff (reset)
      state == ASPC_CONV && timer == 17'h00000 && mode != ASPC_MODE_SCLK |=> !eoc_n)
      else $error("End of conversion not signalled.");
   a_eoc_rise_on_fall: assert property (@(posedge clk) disable iff (reset)
      (sel_fall || start_fall) && !(state == ASPC_CONV && timer == 17'h00000) |=> eoc_n)
      else $error("End of conversion not released.");
   a_conv_latency: assert property (@(posedge clk) disable iff (reset)
      state == ASPC_IDLE ##1 state == ASPC_CONV |-> ##[1:69] state == ASPC_IDLE)
      else $error("Conversion exceeded its latency.");
   a_mode_from_setup: assert property (@(posedge clk) disable iff (reset)
      byte_done && shift_in[6:5] == 2'b01 |=> mode == aspc_mode_type'($past(shift_in[4:3])))
      else $error("Clock mode not taken from setup bits.");
   a_pin_role_one: assert property (@(posedge clk) disable iff (reset)
      !pin_is_start && state == ASPC_IDLE && !sel_rise |=> state == ASPC_IDLE)
      else $error("Start pin acted while an analog input.");
   a_short_start_ignored: assert property (@(posedge clk) disable iff (reset)
      state == ASPC_IDLE && start_rise && mode == ASPC_MODE_PIN_EXT && low_count < 16'(START_LOW_MODE1_CYC)
      |=> state == ASPC_IDLE)
      else $error("Short start pulse accepted in mode 01.");
   a_long_start_taken: assert property (@(posedge clk) disable iff (reset)
      state == ASPC_IDLE && start_rise && mode == ASPC_MODE_PIN_EXT && low_count >= 16'(START_LOW_MODE1_CYC)
      |=> state != ASPC_IDLE)
      else $error("Long start pulse refused in mode 01.");
   a_setup_needs_select: assert property (@(posedge clk) disable iff (reset)
      sync2.select_n |=> $stable(setup))
      else $error("Setup changed while deselected.");
   a_conv_clock_count: assert property (@(posedge clk) disable iff (reset)
      state == ASPC_CONV && $past(state) != ASPC_CONV |-> timer == 17'(CONV_CLOCKS * CONV_CLK_DIV - 1))
      else $error("Conversion clock count not loaded.");
   a_wake_time: assert property (@(posedge clk) disable iff (reset)
      state == ASPC_IDLE ##1 state == ASPC_WAKE |-> ##[1:REF_WAKE_CYC] state == ASPC_CONV)
      else $error("Reference wake exceeded its time.");
   a_result_at_eoc: assert property (@(posedge clk) disable iff (reset)
      $fell(eoc_n) |-> result == {4'h0, $past(sample_value)})
      else $error("Result not ready when end of conversion fell.");
   a_first_bit: assert property (@(posedge clk) disable iff (reset)
      sel_fall |=> dout == $past(result[15]))
      else $error("First result bit not shown after select fell.");
   c_byte_in: cover property (@(posedge clk) byte_done);
   c_conversion_done: cover property (@(posedge clk) $fell(eoc_n));
   c_ref_wake: cover property (@(posedge clk) state == ASPC_WAKE);
   c_long_start: cover property (@(posedge clk) state == ASPC_IDLE && start_rise && start_ok);
   c_bit_out: cover property (@(posedge clk) sclk_fall && dout_oe);
endmodule : aspc_port

// >>> dv/aspc_master.sv
// Purpose: Serial master model driving select, clock, data and start.
// Assumes: Pins change at falling clk edges; the serial clock idles low.
// Notes: A released data line reads as the inverse of its last level.
`timescale 1ns/100ps
module aspc_master
   import aspc_pkg::*;
(
   input wire logic clk,
   input wire logic dout,
   input wire logic dout_oe,
   output aspc_pins_type pins
);
   logic last = 1'b0;
   wire logic line = dout_oe ? dout : ~last;
   always @(posedge clk) if (dout_oe) last <= dout;
   initial pins = 4'b1001;
   task automatic frame(input logic sel_n, input logic [15:0] tx, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      repeat (4) @(negedge clk);
      pins.select_n = sel_n;
      for (int i = 0; i < nbits; i++) begin
         pins.din = tx[15 - i];
         repeat (5) @(negedge clk);
         pins.sclk = 1'b1;
         rx = {rx[14:0], line};
         repeat (5) @(negedge clk);
         pins.sclk = 1'b0;
      end
      repeat (4) @(negedge clk);
      pins.select_n = 1'b1;
      pins.din = ~pins.din;
   endtask : frame
   task automatic pulse(input int n);
      pins.start_or_analog_input_15 = 1'b0;
      repeat (n) @(negedge clk);
      pins.start_or_analog_input_15 = 1'b1;
   endtask : pulse
endmodule : aspc_master

// >>> dv/tb.sv
// Purpose: Self-checking bench for the converter serial port.
// Assumes: Reference wake shortened to 5 cycles.
// Notes: Random values come from a fixed-seed shift register.
`timescale 1ns/100ps
module tb
   import aspc_pkg::*;
;
   localparam int WAKE = 5;
   logic clk = 1'b0, reset = 1'b1, ref_needs_wake = 1'b0;
   logic [11:0] sample_value = 12'h000;
   logic dout, dout_oe, eoc_n;
   logic [7:0] setup;
   logic [15:0] result, rx;
   logic [31:0] seed = 32'h4b270281;
   logic [1:0] md;
   aspc_pins_type pins;
   int n_mismatch = 0, num_checks = 0, lat, lim;
   aspc_port #(.REF_WAKE_CYC(WAKE)) DUT (.clk(clk), .reset(reset), .pins(pins), .ref_needs_wake(ref_needs_wake),
      .sample_value(sample_value), .dout(dout), .dout_oe(dout_oe), .eoc_n(eoc_n), .setup(setup), .result(result));
   aspc_master master (.clk(clk), .dout(dout), .dout_oe(dout_oe), .pins(pins));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wait_eoc(input int n);
      lat = 0;
      while (eoc_n !== 1'b0 && lat < n) begin
         @(negedge clk);
         lat++;
      end
   endtask : wait_eoc
   task automatic conclude;
      $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude
   initial forever #50 clk = ~clk;
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      conclude;
   end
   initial begin
      repeat (16) @(negedge clk);
      reset = 1'b0;
      repeat (3) @(negedge clk);
      check({dout_oe, eoc_n, setup}, {2'b01, SETUP_RESET});
      master.frame(1'b1, 16'h7000, 8, rx);
      check(setup, SETUP_RESET);
      for (int m = 0; m < 5; m++) begin
         seed = lfsr(seed);
         sample_value = seed[11:0];
         md = (m == 4) ? 2'b10 : m[1:0];
         master.frame(1'b0, {2'b01, md, seed[15:12], 8'h00}, 8, rx);
         check(setup, {2'b01, md, seed[15:12]});
         repeat (80) @(negedge clk);
         check(dout_oe, 1'b0);
         ref_needs_wake = (m == 4);
         if (md == 2'b01) begin
            master.pulse(START_LOW_MODE1_CYC - 1);
            wait_eoc(80);
            check(lat, 80);
         end
         if (md[1]) begin
            master.pulse(2);
            master.frame(1'b0, {CONVERT_MARK, 8'h00}, 8, rx);
         end else begin
            master.pulse((md == 2'b01) ? START_LOW_MODE1_CYC : 2);
         end
         lim = CONV_MAX_CYC + ((m == 4) ? WAKE + 1 : 0);
         wait_eoc(lim);
         check(lat < lim && lat >= CONV_CLOCKS * CONV_CLK_DIV, md != 2'b11);
         if (md != 2'b11) check(result, {4'h0, sample_value});
         master.frame(1'b0, 16'h0000, 16, rx);
         if (md != 2'b11) check(rx, {4'h0, sample_value});
         check(eoc_n, 1'b1);
         $display("Test %0d done", m);
      end
      conclude;
   end
endmodule : tb
